/* File: src/pmtc_pkg.sv */
// Constants, register map and carrier types of the power-management timer group
package pmtc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = ADDR_W - 2;
    localparam int NUM_TMR = 3;
    localparam int NUM_IRQ = 16;

    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_EVT_CTRL = 10'h085;
    localparam logic [IDX_W-1:0] IDX_IRQ_SEL = 10'h086;
    localparam logic [IDX_W-1:0] IDX_TMR_CTRL = 10'h088;
    localparam logic [IDX_W-1:0] IDX_CNT_FAST = 10'h089;
    localparam logic [IDX_W-1:0] IDX_CNT_GEN = 10'h08A;
    localparam logic [IDX_W-1:0] IDX_CNT_SLOW = 10'h08B;
    localparam logic [IDX_W-1:0] IDX_RELOAD = 10'h08C;
    localparam logic [IDX_W-1:0] IDX_BLK_CNT = 10'h08D;
    localparam logic [IDX_W-1:0] IDX_THR_ON = 10'h08E;
    localparam logic [IDX_W-1:0] IDX_THR_OFF = 10'h08F;
    localparam logic [IDX_W-1:0] IDX_SLOW_BASE = 10'h096;
    localparam logic [IDX_W-1:0] IDX_INT_STS = 10'h0A0;
    localparam logic [IDX_W-1:0] IDX_INT_CLR = 10'h0A1;
    localparam logic [IDX_W-1:0] IDX_INT_EN = 10'h0A2;
    localparam logic [IDX_W-1:0] IDX_THR_CTRL = 10'h0A3;

    // Timer order: 0 fast, 1 generic, 2 slow
    localparam int TMR_FAST = 0;
    localparam int TMR_GEN = 1;
    localparam int TMR_SLOW = 2;
    localparam int TC_EN_BIT [NUM_TMR] = '{0, 1, 2};
    localparam int TC_BLK_BIT [NUM_TMR] = '{3, 4, 5};
    localparam int RL_BIT [NUM_TMR] = '{2, 1, 0};
    localparam int EV_SET_BIT [NUM_TMR] = '{7, 6, 5};
    localparam int EV_IRQ_REL_BIT = 3;
    localparam int SB_LSB = 14;
    localparam int SB_MSB = 15;
    localparam int THR_EN_BIT = 0;
    localparam int THR_STOP_BIT = 1;
    localparam int INT_MGMT = 3;
    localparam int INT_STOP = 4;
    localparam int INT_W = 5;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [7:0] CNT_DONE = 8'h01;
    localparam logic [7:0] CNT_EXPIRE_FROM = 8'h02;
    localparam logic [3:0] SLOW_MULT [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

    // Tick periods
    localparam longint CLK_NS = 4;
    localparam longint T_SHORT_NS = 35_000;
    localparam longint T_GEN_NS = 300_000_000;
    localparam longint T_FAST_NS = 600_000_000;
    localparam int FAST_PER_GEN = int'(T_FAST_NS / T_GEN_NS);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0] prot;
    } pmtc_addr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [3:0] strb;
    } pmtc_wdata_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0] resp;
    } pmtc_rdata_t;
endpackage : pmtc_pkg

/* File: src/pmtc_top.sv */
// Power-management timers, repeat block and stop-clock throttle behind an AXI4-Lite slave
//
// Summary of operation
// - Selected IRQ request releases stop-clock request
// - Blocking bit halts timer, reloads on resume
// - Disabled timer counts, raises no management interrupt
// - Enable set reloads timer from count register
// - Count write sets count; read returns count
// - Fast timer: count minus one, 0.6 s ticks
// - Generic timer: count minus one, 0.3 s ticks
// - Slow timer tick chosen by two-bit base
// - Reload strobe bits reload fast, generic, slow
// - Repeat block suppresses management interrupts until expiry
// - Throttle-on counts released, expiry asserts stop
// - Throttle timers tick every 35 us
// - Throttle-off counts asserted, expiry releases stop
// - IRQ release only with release enable set
// - Timer expiry with its event set bit asserts stop-clock request
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module pmtc_top #(
    parameter longint TICK_SHORT_CYC = pmtc_pkg::T_SHORT_NS / pmtc_pkg::CLK_NS,
    parameter longint TICK_GEN_CYC = pmtc_pkg::T_GEN_NS / pmtc_pkg::CLK_NS
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire pmtc_pkg::pmtc_addr_t aw_in,
    input wire logic wvalid_in,
    output logic wready_out,
    input wire pmtc_pkg::pmtc_wdata_t w_in,
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    input wire logic arvalid_in,
    output logic arready_out,
    input wire pmtc_pkg::pmtc_addr_t ar_in,
    output logic rvalid_out,
    input wire logic rready_in,
    output pmtc_pkg::pmtc_rdata_t r_out,
    input wire logic [pmtc_pkg::NUM_IRQ-1:0] irq_req_in,
    output logic cpu_stop_clock_request_out,
    output logic mgmt_interrupt_out,
    output logic irq_out
);
    import pmtc_pkg::*;

    localparam int SHORT_W = $clog2(TICK_SHORT_CYC);
    localparam int GEN_W = $clog2(TICK_GEN_CYC);

    function automatic logic [7:0] pmtc_dec(input logic [7:0] c, input logic t);
        return (t && c > CNT_DONE) ? c - 8'h01 : c;
    endfunction : pmtc_dec

    function automatic logic pmtc_expires(input logic [7:0] c, input logic t);
        return t && (c == CNT_EXPIRE_FROM);
    endfunction : pmtc_expires

    function automatic logic pmtc_mapped(input logic [IDX_W-1:0] i);
        return i == IDX_EVT_CTRL || i == IDX_IRQ_SEL || (i >= IDX_TMR_CTRL && i <= IDX_THR_OFF) ||
               i == IDX_SLOW_BASE || (i >= IDX_INT_STS && i <= IDX_THR_CTRL);
    endfunction : pmtc_mapped

    // Bus slave state
    logic aw_pend_q, w_pend_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q;
    logic [IDX_W-1:0] wr_idx_q;
    pmtc_wdata_t w_q;
    pmtc_rdata_t r_q;
    logic wr_fire;
    logic [7:0] wb0;
    logic [15:0] wb01;
    logic [DATA_W-1:0] rd_data;

    // Registers
    logic [7:0] evt_q, ctl_q, ctl_prev_q, blk_load_q, thr_on_q, thr_off_q;
    logic [15:0] irq_sel_q;
    logic [1:0] slow_base_q;
    logic [INT_W-1:0] sts_q, ien_q;
    logic thr_en_q, thr_en_prev_q;
    logic [7:0] load_q [NUM_TMR];
    logic [7:0] cnt_q [NUM_TMR];
    logic [7:0] blk_cnt_q, thr_cnt_q;

    // Ticks
    logic [SHORT_W-1:0] pre_short_q;
    logic [GEN_W-1:0] pre_gen_q;
    logic [1:0] fast_ph_q;
    logic [2:0] slow_ph_q;
    logic tick35, tick_gen, tick_fast, tick_slow;
    logic [NUM_TMR-1:0] tick;

    // Timer and stop-clock control
    logic [NUM_TMR-1:0] wr_cnt, reload, halted, expire, set_hit;
    logic stop_q, stop_prev_q, mgmt_q, irq_q, mgmt_fire, blocked, irq_rel, thr_exp, stop_set, stop_clr;
    logic [NUM_IRQ-1:0] irq_s1_q, irq_s2_q, irq_s3_q, irq_lvl_q;
    logic [INT_W-1:0] int_ev;

    assign awready_out = awready_q;
    assign wready_out = wready_q;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign arready_out = arready_q;
    assign rvalid_out = rvalid_q;
    assign r_out = r_q;
    assign cpu_stop_clock_request_out = stop_q;
    assign mgmt_interrupt_out = mgmt_q;
    assign irq_out = irq_q;

    // Write side: address and data taken in either order, committed together
    assign wr_fire = aw_pend_q && w_pend_q && !bvalid_q;
    assign wb0 = w_q.strb[0] ? w_q.data[7:0] : RST_BYTE;
    assign wb01 = {w_q.strb[1] ? w_q.data[15:8] : RST_BYTE, wb0};

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_pend_q <= 1'b0;
            w_pend_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            wr_idx_q <= '0;
            w_q <= '0;
        end else begin
            if (awvalid_in && awready_q) begin
                aw_pend_q <= 1'b1;
                awready_q <= 1'b0;
                wr_idx_q <= aw_in.addr[ADDR_W-1:2];
            end
            if (wvalid_in && wready_q) begin
                w_pend_q <= 1'b1;
                wready_q <= 1'b0;
                w_q <= w_in;
            end
            if (wr_fire) begin
                aw_pend_q <= 1'b0;
                w_pend_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
                bvalid_q <= 1'b1;
                bresp_q <= pmtc_mapped(wr_idx_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read side; timer count registers return the live count
    always_comb begin
        rd_data = '0;
        unique case (ar_in.addr[ADDR_W-1:2])
            IDX_EVT_CTRL: rd_data[7:0] = evt_q;
            IDX_IRQ_SEL: rd_data[15:0] = irq_sel_q;
            IDX_TMR_CTRL: rd_data[7:0] = ctl_q;
            IDX_CNT_FAST: rd_data[7:0] = cnt_q[TMR_FAST];
            IDX_CNT_GEN: rd_data[7:0] = cnt_q[TMR_GEN];
            IDX_CNT_SLOW: rd_data[7:0] = cnt_q[TMR_SLOW];
            IDX_BLK_CNT: rd_data[7:0] = blk_load_q;
            IDX_THR_ON: rd_data[7:0] = thr_on_q;
            IDX_THR_OFF: rd_data[7:0] = thr_off_q;
            IDX_SLOW_BASE: rd_data[SB_MSB:SB_LSB] = slow_base_q;
            IDX_INT_STS: rd_data[INT_W-1:0] = sts_q;
            IDX_INT_EN: rd_data[INT_W-1:0] = ien_q;
            IDX_THR_CTRL: rd_data[THR_STOP_BIT:THR_EN_BIT] = {stop_q, thr_en_q};
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            r_q <= '0;
        end else if (arvalid_in && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            r_q.data <= rd_data;
            r_q.resp <= pmtc_mapped(ar_in.addr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && rready_in) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Configuration registers, all cleared at reset
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            evt_q <= RST_BYTE;
            ctl_q <= RST_BYTE;
            irq_sel_q <= RST_HALF;
            blk_load_q <= RST_BYTE;
            thr_on_q <= RST_BYTE;
            thr_off_q <= RST_BYTE;
            slow_base_q <= '0;
            ien_q <= '0;
            thr_en_q <= 1'b0;
        end else if (wr_fire) begin
            unique case (wr_idx_q)
                IDX_EVT_CTRL: evt_q <= wb0;
                IDX_IRQ_SEL: irq_sel_q <= wb01;
                IDX_TMR_CTRL: ctl_q <= wb0;
                IDX_BLK_CNT: blk_load_q <= wb0;
                IDX_THR_ON: thr_on_q <= wb0;
                IDX_THR_OFF: thr_off_q <= wb0;
                IDX_SLOW_BASE: slow_base_q <= w_q.strb[1] ? w_q.data[SB_MSB:SB_LSB] : slow_base_q;
                IDX_INT_EN: ien_q <= wb0[INT_W-1:0];
                IDX_THR_CTRL: thr_en_q <= wb0[THR_EN_BIT];
                default: ;
            endcase
        end
    end

    // Prescaler: 35 us, 0.3 s, 0.6 s and selectable slow base
    assign tick35 = (pre_short_q == SHORT_W'(TICK_SHORT_CYC - 1));
    assign tick_gen = (pre_gen_q == GEN_W'(TICK_GEN_CYC - 1));
    assign tick_fast = tick_gen && (fast_ph_q == 2'(FAST_PER_GEN - 1));
    assign tick_slow = tick_fast && (slow_ph_q == 3'(SLOW_MULT[slow_base_q] - 4'h1));
    assign tick = {tick_slow, tick_gen, tick_fast};

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_short_q <= '0;
            pre_gen_q <= '0;
            fast_ph_q <= '0;
            slow_ph_q <= '0;
        end else begin
            pre_short_q <= tick35 ? '0 : pre_short_q + SHORT_W'(1);
            pre_gen_q <= tick_gen ? '0 : pre_gen_q + GEN_W'(1);
            if (tick_gen) begin
                fast_ph_q <= tick_fast ? 2'h0 : fast_ph_q + 2'h1;
            end
            if (tick_fast) begin
                slow_ph_q <= tick_slow ? 3'h0 : slow_ph_q + 3'h1;
            end
        end
    end

    // Three interval timers
    always_comb begin
        for (int i = 0; i < NUM_TMR; i++) begin
            wr_cnt[i] = wr_fire && w_q.strb[0] && (wr_idx_q == IDX_CNT_FAST + IDX_W'(i));
            reload[i] = (wr_fire && w_q.strb[0] && wr_idx_q == IDX_RELOAD && w_q.data[RL_BIT[i]]) ||
                        (ctl_q[TC_EN_BIT[i]] && !ctl_prev_q[TC_EN_BIT[i]]) ||
                        (stop_prev_q && !stop_q && ctl_q[TC_BLK_BIT[i]]);
            halted[i] = stop_q && ctl_q[TC_BLK_BIT[i]];
            expire[i] = pmtc_expires(cnt_q[i], tick[i]) && !halted[i] && !wr_cnt[i] && !reload[i];
            set_hit[i] = expire[i] && evt_q[EV_SET_BIT[i]];
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                load_q[i] <= RST_BYTE;
                cnt_q[i] <= RST_BYTE;
            end
            ctl_prev_q <= RST_BYTE;
        end else begin
            ctl_prev_q <= ctl_q;
            for (int i = 0; i < NUM_TMR; i++) begin
                if (wr_cnt[i]) begin
                    load_q[i] <= wb0;
                    cnt_q[i] <= wb0;
                end else if (reload[i]) begin
                    cnt_q[i] <= load_q[i];
                end else if (!halted[i]) begin
                    cnt_q[i] <= pmtc_dec(cnt_q[i], tick[i]);
                end
            end
        end
    end

    // Management interrupt and its repeat block
    assign blocked = blk_cnt_q > CNT_DONE;
    assign mgmt_fire = |(expire & ctl_q[TC_EN_BIT[TMR_SLOW]:TC_EN_BIT[TMR_FAST]]) && !blocked;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mgmt_q <= 1'b0;
            blk_cnt_q <= RST_BYTE;
        end else begin
            mgmt_q <= mgmt_fire;
            blk_cnt_q <= mgmt_fire ? blk_load_q : pmtc_dec(blk_cnt_q, tick35);
        end
    end

    // IRQ inputs: three flops, a change counts once the last two agree
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_s1_q <= '0;
            irq_s2_q <= '0;
            irq_s3_q <= '0;
            irq_lvl_q <= '0;
        end else begin
            irq_s1_q <= irq_req_in;
            irq_s2_q <= irq_s1_q;
            irq_s3_q <= irq_s2_q;
            irq_lvl_q <= (irq_s2_q & irq_s3_q) | (irq_lvl_q & (irq_s2_q | irq_s3_q));
        end
    end

    // Stop-clock request and throttle timer
    assign irq_rel = evt_q[EV_IRQ_REL_BIT] && |(irq_sel_q & irq_lvl_q);
    assign thr_exp = thr_en_q && thr_en_prev_q && (stop_q == stop_prev_q) && pmtc_expires(thr_cnt_q, tick35);
    assign stop_set = |set_hit || (thr_exp && !stop_q);
    assign stop_clr = irq_rel || (thr_exp && stop_q);

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stop_q <= 1'b0;
            stop_prev_q <= 1'b0;
            thr_en_prev_q <= 1'b0;
            thr_cnt_q <= RST_BYTE;
        end else begin
            stop_prev_q <= stop_q;
            thr_en_prev_q <= thr_en_q;
            if (stop_set) begin
                stop_q <= 1'b1;
            end else if (stop_clr) begin
                stop_q <= 1'b0;
            end
            if ((thr_en_q && !thr_en_prev_q) || stop_q != stop_prev_q) begin
                thr_cnt_q <= stop_q ? thr_off_q : thr_on_q;
            end else begin
                thr_cnt_q <= pmtc_dec(thr_cnt_q, tick35);
            end
        end
    end

    // Sticky interrupt status, set wins over clear
    assign int_ev = {stop_q && !stop_prev_q, mgmt_fire, expire};

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= (sts_q & ~((wr_fire && wr_idx_q == IDX_INT_CLR) ? wb0[INT_W-1:0] : '0)) | int_ev;
            irq_q <= |(sts_q & ien_q);
        end
    end

    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    chk_block_stops_mgmt: assert property ((blocked && |expire) |=> !mgmt_q)
        else $error("management interrupt raised while repeat block ran");
    chk_mgmt_needs_enable: assert property (mgmt_q |-> $past(|(expire & ctl_q[TC_EN_BIT[TMR_SLOW]:TC_EN_BIT[TMR_FAST]])))
        else $error("management interrupt without an enabled expiry");
    chk_mgmt_loads_block: assert property (mgmt_q && $past(blk_load_q) > CNT_DONE |-> blocked)
        else $error("repeat block not started after interrupt");
    chk_expiry_sets_stop: assert property (|set_hit |=> stop_q)
        else $error("enabled expiry did not assert stop clock");
    chk_irq_release: assert property ((irq_rel && !stop_set) |=> !stop_q)
        else $error("selected IRQ did not release stop clock");
    chk_release_gated: assert property ((stop_q && !thr_exp && !evt_q[EV_IRQ_REL_BIT]) |=> stop_q)
        else $error("stop clock state inconsistent with release gate");
    chk_enable_loads: assert property ((ctl_q[0] && !ctl_prev_q[0] && !wr_cnt[0]) |=> cnt_q[0] == $past(load_q[0]))
        else $error("enable did not reload fast timer");
    chk_halt_holds: assert property ((halted[1] && !wr_cnt[1] && !reload[1]) |=> $stable(cnt_q[1]))
        else $error("blocked generic timer kept counting");
    chk_reload_strobe: assert property ((wr_fire && wr_idx_q == IDX_RELOAD && w_q.strb[0] && w_q.data[0])
        |=> cnt_q[TMR_SLOW] == $past(load_q[TMR_SLOW]))
        else $error("reload strobe did not reload slow timer");
    chk_throttle_on: assert property ((thr_exp && !stop_q) |=> stop_q ##1 thr_cnt_q == $past(thr_off_q))
        else $error("throttle-on expiry did not assert stop clock");
    chk_tick_bound: assert property (pre_short_q <= SHORT_W'(TICK_SHORT_CYC - 1))
        else $error("short prescaler overran its period");
endmodule : pmtc_top

/* File: dv/pmtc_cpu_model.sv */
// Host CPU model: counts management interrupts and times stop-clock phases
`timescale 1ns/1ps
module pmtc_cpu_model (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic stop_in,
    input wire logic mgmt_in,
    output int n_mgmt_out,
    output int hi_len_out,
    output int lo_len_out
);
    logic stop_q;
    int run_q;

    // Every one-cycle pulse is one interrupt taken by the CPU
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            n_mgmt_out <= 0;
        end else if (mgmt_in) begin
            n_mgmt_out <= n_mgmt_out + 1;
        end
    end

    // Length of the last completed stopped and running phase
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stop_q <= 1'b0;
            run_q <= 0;
            hi_len_out <= 0;
            lo_len_out <= 0;
        end else if (stop_in == stop_q) begin
            run_q <= run_q + 1;
        end else begin
            if (stop_q) begin
                hi_len_out <= run_q;
            end else begin
                lo_len_out <= run_q;
            end
            stop_q <= stop_in;
            run_q <= 1;
        end
    end
endmodule : pmtc_cpu_model

/* File: dv/tb_top.sv */
// Self-checking testbench for the power-management timer group
`timescale 1ns/1ps
module tb_top;
    import pmtc_pkg::*;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    pmtc_addr_t aw = '0, ar = '0;
    pmtc_wdata_t w = '0;
    pmtc_rdata_t r;
    logic [NUM_IRQ-1:0] irq_req = '0;
    logic awready, wready, bvalid, arready, rvalid, stop, mgmt, irq;
    logic [1:0] bresp, rs;
    logic [31:0] rdat;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int n_mgmt, hi_len, lo_len;

    initial forever #2 clock_in = ~clock_in;

    pmtc_top #(.TICK_SHORT_CYC(4), .TICK_GEN_CYC(8)) dut (
        .clock_in(clock_in), .nrst_in(nrst_in),
        .awvalid_in(awvalid), .awready_out(awready), .aw_in(aw),
        .wvalid_in(wvalid), .wready_out(wready), .w_in(w),
        .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
        .arvalid_in(arvalid), .arready_out(arready), .ar_in(ar),
        .rvalid_out(rvalid), .rready_in(rready), .r_out(r),
        .irq_req_in(irq_req), .cpu_stop_clock_request_out(stop),
        .mgmt_interrupt_out(mgmt), .irq_out(irq)
    );

    pmtc_cpu_model cpu (
        .clock_in(clock_in), .nrst_in(nrst_in), .stop_in(stop), .mgmt_in(mgmt),
        .n_mgmt_out(n_mgmt), .hi_len_out(hi_len), .lo_len_out(lo_len)
    );

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        @(posedge clock_in);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw <= '{addr: {idx, 2'b00}, prot: 3'h0};
        w <= '{data: d, strb: 4'hF};
        forever begin
            @(posedge clock_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [IDX_W-1:0] idx);
        @(posedge clock_in);
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar <= '{addr: {idx, 2'b00}, prot: 3'h0};
        forever begin
            @(posedge clock_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rdat = r.data;
                rs = r.resp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd(IDX_TMR_CTRL);
        chk("timer_control reset", 32'h0, rdat);
        rd(IDX_CNT_FAST);
        chk("fast_timer_count reset", 32'h0, rdat);
        rd(IDX_THR_OFF);
        chk("throttle_off_count reset", 32'h0, rdat);
        wr(IDX_IRQ_SEL, 32'h0000BEEF);
        chk("mapped write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
        rd(IDX_IRQ_SEL);
        chk("irq_wake_select rw", 32'h0000BEEF, rdat);
        rd(IDX_RELOAD);
        chk("reload strobe reads zero", 32'h0, rdat);
        rd(10'h3FF);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("unmapped data", 32'h0, rdat);
        wr(10'h3FF, 32'h5);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        // Disabled generic timer still runs down to expiry
        wr(IDX_CNT_GEN, 32'h5);
        repeat (50) @(posedge clock_in);
        rd(IDX_CNT_GEN);
        chk("disabled generic expired", 32'h1, rdat);
        chk("no interrupt while disabled", 32'h0, n_mgmt);
        wr(IDX_BLK_CNT, 32'hC8);
        wr(IDX_INT_EN, 32'h0A);
        wr(IDX_TMR_CTRL, 32'h2);
        repeat (18) @(posedge clock_in);
        chk("generic not yet expired", 32'h0, n_mgmt);
        repeat (30) @(posedge clock_in);
        chk("generic expiry interrupt", 32'h1, n_mgmt);
        rd(IDX_INT_STS);
        chk("status sticky", 32'h0A, rdat & 32'h0A);
        chk("irq line high", 32'h1, {31'h0, irq});
        wr(IDX_INT_CLR, 32'h1F);
        repeat (3) @(posedge clock_in);
        chk("irq line cleared", 32'h0, {31'h0, irq});
        // Second expiry inside the repeat-block interval is suppressed
        wr(IDX_RELOAD, 32'h2);
        rd(IDX_CNT_GEN);
        chk("generic reloaded", 32'h1, {31'h0, rdat inside {32'h4, 32'h5}});
        repeat (60) @(posedge clock_in);
        chk("repeat block holds", 32'h1, n_mgmt);
        repeat (800) @(posedge clock_in);
        wr(IDX_RELOAD, 32'h2);
        repeat (60) @(posedge clock_in);
        chk("interrupt after block", 32'h2, n_mgmt);
        // Expiry asserts stop-clock, selected IRQ releases it only when enabled
        wr(IDX_EVT_CTRL, 32'h40);
        wr(IDX_RELOAD, 32'h2);
        repeat (60) @(posedge clock_in);
        chk("expiry asserts stop", 32'h1, {31'h0, stop});
        wr(IDX_IRQ_SEL, 32'h0020);
        irq_req <= 16'h0020;
        repeat (10) @(posedge clock_in);
        chk("release disabled", 32'h1, {31'h0, stop});
        // Generic blocking bit: timer holds its count while stop-clock stands
        wr(IDX_TMR_CTRL, 32'h12);
        wr(IDX_CNT_GEN, 32'h5);
        repeat (40) @(posedge clock_in);
        rd(IDX_CNT_GEN);
        chk("blocked timer halts", 32'h5, rdat);
        wr(IDX_EVT_CTRL, 32'h08);
        repeat (10) @(posedge clock_in);
        chk("irq releases stop", 32'h0, {31'h0, stop});
        irq_req <= 16'h0000;
        // Throttle: running phase (3-1)*4 cycles, stopped phase (5-1)*4 cycles
        wr(IDX_EVT_CTRL, 32'h0);
        wr(IDX_THR_ON, 32'h3);
        wr(IDX_THR_OFF, 32'h5);
        wr(IDX_THR_CTRL, 32'h1);
        repeat (120) @(posedge clock_in);
        chk("stopped phase", 32'h1, {31'h0, hi_len >= 12 && hi_len <= 16});
        chk("running phase", 32'h1, {31'h0, lo_len >= 4 && lo_len <= 8});
        // Slow timer on the longest base: four ticks of 128 cycles, disabled
        wr(IDX_SLOW_BASE, 32'h0000C000);
        wr(IDX_CNT_SLOW, 32'h5);
        wr(IDX_RELOAD, 32'h1);
        repeat (300) @(posedge clock_in);
        rd(IDX_CNT_SLOW);
        chk("slow base not expired", 32'h1, {31'h0, rdat inside {32'h2, 32'h3}});
        repeat (300) @(posedge clock_in);
        rd(IDX_CNT_SLOW);
        chk("slow expired", 32'h1, rdat);
        chk("disabled slow no interrupt", 32'h2, n_mgmt);
        // Fast timer enabled after the repeat block has run out
        wr(IDX_CNT_FAST, 32'h3);
        wr(IDX_TMR_CTRL, 32'h13);
        repeat (50) @(posedge clock_in);
        rd(IDX_CNT_FAST);
        chk("fast expired", 32'h1, rdat);
        chk("fast expiry interrupt", 32'h3, n_mgmt);
        print_verdict();
    end
endmodule : tb_top
